// ==== cpuma_checker.sv ====
`timescale 1ns/100ps
module cpuma_checker import cpuma_pkg::*; (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Fetch and shifter
  input wire logic [31:0] ifAddr,
  input wire logic shStart,
  input cpuma_shop_t shOp,
  input wire logic [4:0] shAmount,
  input wire logic shDone,
  // Masters
  input cpuma_mreq_t imReq,
  input wire logic imWaitrequest,
  input cpuma_mreq_t dmReq,
  input wire logic dmWaitrequest,
  // Register bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  logic wrPh, hwMul;
  logic [5:0] shCnt;
  logic [4:0] shAmt;
  // Mirror of the multiplier mode bit, updated in the write data phase
  always_ff @(posedge mclk) begin
    if (srst) begin
      wrPh <= 1'b0;
      hwMul <= 1'b1;
    end else begin
      wrPh <= hsel && hready && htrans[1] && hwrite && haddr[11:0] == REG_CTRL;
      hwMul <= wrPh ? hwdata[CTRL_HWMUL] : hwMul;
    end
  end
  // Cycles since the last shift start
  always_ff @(posedge mclk) begin
    shCnt <= shStart ? 6'h1 : shCnt + 6'h1;
    shAmt <= shStart ? shAmount : shAmt;
  end
  shift_hw_a: assert property (shStart && hwMul && shOp < SH_ROL |-> ##1 !shDone[*2] ##1 shDone)
    else $error("fast shift timing wrong");
  rotate_hw_a: assert property (shStart && hwMul && shOp >= SH_ROL |-> ##1 !shDone[*3] ##1 shDone)
    else $error("fast rotate timing wrong");
  shift_serial_a: assert property (shDone && !hwMul |-> shCnt == {1'b0, shAmt} + 6'h1)
    else $error("serial shift timing wrong");
  crit_first_a: assert property ($rose(imReq.read) |-> imReq.addr[30:2] == ifAddr[30:2])
    else $error("fill does not start at critical word");
  ifill_step_a: assert property (imReq.read && !imWaitrequest ##1 imReq.read
    |-> {imReq.addr[31:5], imReq.addr[4:2] - 3'h1} == $past(imReq.addr[31:2]))
    else $error("instruction fill order wrong");
  dfill_step_a: assert property (dmReq.read && !dmWaitrequest ##1 dmReq.read && dmReq.burstcount == BURST_ONE
    |-> {dmReq.addr[31:5], dmReq.addr[4:2] - 3'h1} == $past(dmReq.addr[31:2]))
    else $error("data fill order wrong");
  burst_shape_a: assert property (dmReq.read && dmReq.burstcount != BURST_ONE
    |-> dmReq.burstcount == BURST_LEN && dmReq.addr[4:0] == 5'h0)
    else $error("burst shape wrong");
  addr_width_a: assert property (dmReq.read || dmReq.write || imReq.read |-> !dmReq.addr[31] && !imReq.addr[31])
    else $error("address bit 31 driven");
  hold_req_a: assert property (dmReq.read && dmWaitrequest |=> $stable(dmReq))
    else $error("data request dropped while stalled");
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus response not okay");
  // Main scenarios reached
  cover property ($rose(imReq.read));
  cover property (dmReq.read && dmReq.burstcount == BURST_LEN);
  cover property (dmReq.write && !dmWaitrequest);
  cover property (shDone && !hwMul);
endmodule // cpuma_checker

// ==== cpuma_core.sv ====
// Our own choices: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/100ps
module cpuma_core import cpuma_pkg::*; (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Instruction fetch from the pipeline
  input wire logic ifReq,
  input wire logic [31:0] ifAddr,
  input wire logic [PFN_W-1:0] fetch_physical_frame_number,
  output logic ifReady,
  output logic [31:0] ifData,
  // Data access from the pipeline
  input cpuma_dreq_t dReq,
  input wire logic [PFN_W-1:0] physical_frame_number,
  input wire logic tlbUncached,
  output logic dReady,
  output logic [31:0] dRdata,
  // Shift and rotate unit
  input wire logic shStart,
  input cpuma_shop_t shOp,
  input wire logic [31:0] shValue,
  input wire logic [4:0] shAmount,
  output logic shDone,
  output logic [31:0] shResult,
  // Instruction master
  output cpuma_mreq_t imReq,
  input wire logic imWaitrequest,
  input wire logic imReadvalid,
  input wire logic [31:0] imReaddata,
  // Data master
  output cpuma_mreq_t dmReq,
  input wire logic dmWaitrequest,
  input wire logic dmReadvalid,
  input wire logic [31:0] dmReaddata,
  // AHB-Lite register slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata
);

  logic [1:0] ctrl_reg;
  logic shBusy;
  logic burstOn;
  logic hwMul;
  assign burstOn = ctrl_reg[CTRL_BURST];
  assign hwMul = ctrl_reg[CTRL_HWMUL];

  // ---------------- Instruction cache ----------------
  logic [31:0] icData [IC_LINES][8];
  logic [IC_TAG_W-1:0] icTag [IC_LINES];
  logic [IC_LINES-1:0] icValid_reg;
  cpuma_icst_t icState_reg, icState_next;
  logic [IC_IDX_W-1:0] icFillIdx_reg;
  logic [IC_TAG_W-1:0] icFillTag_reg;
  logic [WSEL_W-1:0] icCrit_reg;
  logic [3:0] icIssue_reg;
  logic [WSEL_W-1:0] icRet_reg;
  logic icUncSent_reg;
  logic [31:0] icUnc_reg;
  logic [PADDR_W-1:0] ifPaddr;
  logic [PADDR_W-1:0] dPaddr;

  // Physical address: frame number with MMU, bit 31 stripped without
  generate
    if (MMU_ON != 0) begin : g_mmu
      assign ifPaddr = {fetch_physical_frame_number, ifAddr[PAGE_W-1:0]};
      assign dPaddr = {physical_frame_number, dReq.addr[PAGE_W-1:0]};
    end else begin : g_nommu
      assign ifPaddr = ifAddr[PADDR_W-1:0];
      assign dPaddr = dReq.addr[PADDR_W-1:0];
    end
  endgenerate

  // Fetch address fields; index is taken from the virtual address
  wire [IC_IDX_W-1:0] icIdx = ifAddr[OFF_W +: IC_IDX_W];
  wire [IC_TAG_W-1:0] icTagIn = ifPaddr[PADDR_W-1 -: IC_TAG_W];
  wire [WSEL_W-1:0] icWord = ifAddr[2 +: WSEL_W];
  wire icHit = icValid_reg[icIdx] && (icTag[icIdx] == icTagIn);
  wire ifInTcm = (ifAddr & TCM_MASK) == TCM_BASE;
  wire [WSEL_W-1:0] icIssueWord = WSEL_W'(icCrit_reg + icIssue_reg[WSEL_W-1:0]);
  wire [WSEL_W-1:0] icRetWord = WSEL_W'(icCrit_reg + icRet_reg);
  wire icFill = icState_reg == IC_FILL;
  wire icUnc = icState_reg == IC_UNC;
  wire icRead = (icFill && icIssue_reg < WORDS_N) || (icUnc && !icUncSent_reg);
  wire icAccept = icRead && !imWaitrequest;
  wire [31:0] icFillAddr = 32'({icFillTag_reg, icFillIdx_reg, icIssueWord, 2'b00});

  // Instruction master request
  assign imReq = '{read: icRead, write: 1'b0, addr: icFill ? icFillAddr : ifAddr,
                   wdata: 32'h0, burstcount: BURST_ONE};
  // Fetch answer; tightly-coupled spans never hit the cache
  assign ifReady = (icState_reg == IC_IDLE && ifReq && !ifInTcm && icHit) || icState_reg == IC_RESP;
  assign ifData = (icState_reg == IC_RESP) ? icUnc_reg : icData[icIdx][icWord];

  // Instruction cache sequencing
  always_comb begin
    icState_next = icState_reg;
    case (icState_reg)
      IC_IDLE: begin
        if (ifReq && ifInTcm) icState_next = IC_UNC;
        else if (ifReq && !icHit) icState_next = IC_FILL;
      end
      IC_FILL: begin
        if (imReadvalid && icRet_reg == WORD_LAST) icState_next = IC_IDLE;
      end
      IC_UNC: begin
        if (icUncSent_reg && imReadvalid) icState_next = IC_RESP;
      end
      IC_RESP: icState_next = IC_IDLE;
      default: icState_next = IC_IDLE;
    endcase
  end

  // Instruction cache control state
  always_ff @(posedge mclk) begin
    if (srst) begin
      icState_reg <= IC_IDLE;
      icValid_reg <= '0;
      icFillIdx_reg <= '0;
      icFillTag_reg <= '0;
      icCrit_reg <= '0;
      icIssue_reg <= '0;
      icRet_reg <= '0;
      icUncSent_reg <= 1'b0;
      icUnc_reg <= 32'h0;
    end else begin
      icState_reg <= icState_next;
      if (icState_reg == IC_IDLE) begin
        icFillIdx_reg <= icIdx;
        icFillTag_reg <= icTagIn;
        icCrit_reg <= icWord;
        icIssue_reg <= '0;
        icRet_reg <= '0;
        icUncSent_reg <= 1'b0;
        if (icState_next == IC_FILL) icValid_reg[icIdx] <= 1'b0;
      end
      if (icAccept && icFill) icIssue_reg <= icIssue_reg + CNT_ONE;
      if (icAccept && icUnc) icUncSent_reg <= 1'b1;
      if (imReadvalid && icFill) begin
        icRet_reg <= icRet_reg + 3'h1;
        if (icRet_reg == WORD_LAST) icValid_reg[icFillIdx_reg] <= 1'b1;
      end
      if (imReadvalid && icUnc && icUncSent_reg) icUnc_reg <= imReaddata;
    end
  end

  // Instruction line storage
  always_ff @(posedge mclk) begin
    if (imReadvalid && icFill) begin
      icData[icFillIdx_reg][icRetWord] <= imReaddata;
      icTag[icFillIdx_reg] <= icFillTag_reg;
    end
  end

  // ---------------- Data cache ----------------
  logic [31:0] dcData [DC_LINES][8];
  logic [DC_TAG_W-1:0] dcTag [DC_LINES];
  logic [DC_LINES-1:0] dcValid_reg;
  logic [DC_LINES-1:0] dcDirty_reg;
  cpuma_dcst_t dcState_reg, dcState_next;
  logic [DC_IDX_W-1:0] dcVicIdx_reg;
  logic [DC_TAG_W-1:0] dcVicTag_reg;
  logic [DC_TAG_W-1:0] dcFillTag_reg;
  logic dcOpMode_reg;
  logic dcBurst_reg;
  logic [3:0] dcBeat_reg;
  logic [3:0] dcIssue_reg;
  logic [WSEL_W-1:0] dcRet_reg;
  logic dcUncSent_reg;
  logic [31:0] dcUnc_reg;

  // Data address fields and lookup
  wire [DC_IDX_W-1:0] dcIdx = dReq.addr[OFF_W +: DC_IDX_W];
  wire [DC_TAG_W-1:0] dcTagIn = dPaddr[PADDR_W-1 -: DC_TAG_W];
  wire [WSEL_W-1:0] dcWord = dReq.addr[2 +: WSEL_W];
  wire dcHit = dcValid_reg[dcIdx] && (dcTag[dcIdx] == dcTagIn);
  wire dcLineDirty = dcValid_reg[dcIdx] && dcDirty_reg[dcIdx];
  wire dcInTcm = (dReq.addr & TCM_MASK) == TCM_BASE;
  wire dcRegionUnc = (MMU_ON != 0) ? tlbUncached : dReq.addr[BYPASS_BIT];
  wire dcUncAcc = dReq.bypass || dcRegionUnc || dcInTcm;
  // Cache operation decode
  wire dcOp = dReq.op != CO_NONE;
  wire dcOpByIdx = dReq.op == CO_FLUSH_IDX || dReq.op == CO_INV_IDX;
  wire dcOpFlush = dReq.op == CO_FLUSH_IDX || dReq.op == CO_FLUSH_ADDR;
  wire dcOpSel = dcOpByIdx || dcHit;
  wire dcOpWb = dcOpFlush && dcOpSel && dcLineDirty;
  // Decisions taken while idle
  wire dcIdle = dcState_reg == DC_IDLE;
  wire dcOpDone = dReq.req && dcOp && (dcInTcm || !dcOpWb);
  wire dcHitDone = dReq.req && !dcOp && !dcUncAcc && dcHit;
  wire dcMiss = dReq.req && !dcOp && !dcUncAcc && !dcHit;
  wire dcGoWb = (dReq.req && dcOp && !dcInTcm && dcOpWb) || (dcMiss && dcLineDirty);
  wire dcGoFill = dcMiss && !dcLineDirty;
  wire dcGoUnc = dReq.req && !dcOp && dcUncAcc;
  // Master sequencing
  wire dcWb = dcState_reg == DC_WBACK;
  wire dcFill = dcState_reg == DC_FILL;
  wire dcUnc = dcState_reg == DC_UNC;
  wire [3:0] dcIssueLim = dcBurst_reg ? CNT_ONE : WORDS_N;
  wire dcRead = (dcFill && dcIssue_reg < dcIssueLim) || (dcUnc && !dReq.write && !dcUncSent_reg);
  wire dcWrite = (dcWb && dcBeat_reg < WORDS_N) || (dcUnc && dReq.write);
  wire dcAccept = (dcRead || dcWrite) && !dmWaitrequest;
  wire [WSEL_W-1:0] dcBeatWord = dcBurst_reg ? 3'h0 : dcBeat_reg[WSEL_W-1:0];
  wire [WSEL_W-1:0] dcIssueWord = dcBurst_reg ? 3'h0 : dcIssue_reg[WSEL_W-1:0];
  wire [31:0] dcWbAddr = 32'({dcVicTag_reg, dcVicIdx_reg, dcBeatWord, 2'b00});
  wire [31:0] dcFillAddr = 32'({dcFillTag_reg, dcVicIdx_reg, dcIssueWord, 2'b00});
  wire [31:0] dcAddrOut = dcWb ? dcWbAddr : (dcFill ? dcFillAddr : 32'(dPaddr));
  wire [31:0] dcWdataOut = dcWb ? dcData[dcVicIdx_reg][dcBeat_reg[WSEL_W-1:0]] : dReq.wdata;
  wire [3:0] dcBurstOut = ((dcWb || dcFill) && dcBurst_reg) ? BURST_LEN : BURST_ONE;

  // Data master request
  assign dmReq = '{read: dcRead, write: dcWrite, addr: dcAddrOut,
                   wdata: dcWdataOut, burstcount: dcBurstOut};
  // Data answer to the pipeline
  assign dReady = (dcIdle && (dcOpDone || dcHitDone)) || dcState_reg == DC_RESP;
  assign dRdata = (dcState_reg == DC_RESP) ? dcUnc_reg : dcData[dcIdx][dcWord];

  // Data cache sequencing
  always_comb begin
    dcState_next = dcState_reg;
    case (dcState_reg)
      DC_IDLE: begin
        if (dcGoWb) dcState_next = DC_WBACK;
        else if (dcGoFill) dcState_next = DC_FILL;
        else if (dcGoUnc) dcState_next = DC_UNC;
      end
      DC_WBACK: begin
        if (dcAccept && dcBeat_reg[WSEL_W-1:0] == WORD_LAST) begin
          dcState_next = dcOpMode_reg ? DC_IDLE : DC_FILL;
        end
      end
      DC_FILL: begin
        if (dmReadvalid && dcRet_reg == WORD_LAST) dcState_next = DC_IDLE;
      end
      DC_UNC: begin
        if (dReq.write && dcAccept) dcState_next = DC_RESP;
        else if (!dReq.write && dcUncSent_reg && dmReadvalid) dcState_next = DC_RESP;
      end
      DC_RESP: dcState_next = DC_IDLE;
      default: dcState_next = DC_IDLE;
    endcase
  end

  // Data cache control state
  always_ff @(posedge mclk) begin
    if (srst) begin
      dcState_reg <= DC_IDLE;
      dcValid_reg <= '0;
      dcDirty_reg <= '0;
      dcVicIdx_reg <= '0;
      dcVicTag_reg <= '0;
      dcFillTag_reg <= '0;
      dcOpMode_reg <= 1'b0;
      dcBurst_reg <= 1'b0;
      dcBeat_reg <= '0;
      dcIssue_reg <= '0;
      dcRet_reg <= '0;
      dcUncSent_reg <= 1'b0;
      dcUnc_reg <= 32'h0;
    end else begin
      dcState_reg <= dcState_next;
      if (dcIdle) begin
        dcVicIdx_reg <= dcIdx;
        dcVicTag_reg <= dcTag[dcIdx];
        dcFillTag_reg <= dcTagIn;
        dcOpMode_reg <= dcOp;
        dcBurst_reg <= burstOn;
        dcBeat_reg <= '0;
        dcIssue_reg <= '0;
        dcRet_reg <= '0;
        dcUncSent_reg <= 1'b0;
        if (dcOpDone && dcOpSel && !dcInTcm) begin
          dcValid_reg[dcIdx] <= 1'b0;
          dcDirty_reg[dcIdx] <= 1'b0;
        end
        if (dcHitDone && dReq.write) dcDirty_reg[dcIdx] <= 1'b1;
        if (dcGoWb || dcGoFill) begin
          dcValid_reg[dcIdx] <= 1'b0;
          dcDirty_reg[dcIdx] <= 1'b0;
        end
      end
      if (dcAccept && dcWb) dcBeat_reg <= dcBeat_reg + CNT_ONE;
      if (dcAccept && dcFill) dcIssue_reg <= dcIssue_reg + CNT_ONE;
      if (dcAccept && dcUnc) dcUncSent_reg <= 1'b1;
      if (dmReadvalid && dcFill) begin
        dcRet_reg <= dcRet_reg + 3'h1;
        if (dcRet_reg == WORD_LAST) dcValid_reg[dcVicIdx_reg] <= 1'b1;
      end
      if (dmReadvalid && dcUnc && dcUncSent_reg) dcUnc_reg <= dmReaddata;
    end
  end

  // Data line storage: store hits and line fills
  always_ff @(posedge mclk) begin
    if (dcIdle && dcHitDone && dReq.write) dcData[dcIdx][dcWord] <= dReq.wdata;
    if (dmReadvalid && dcFill) begin
      dcData[dcVicIdx_reg][dcRet_reg] <= dmReaddata;
      dcTag[dcVicIdx_reg] <= dcFillTag_reg;
    end
  end

  // ---------------- Shift and rotate unit ----------------
  cpuma_shst_t shState_reg;
  logic [31:0] shWork_reg;
  logic [4:0] shCnt_reg;
  cpuma_shop_t shOp_reg;
  logic shSerial_reg;

  // Whole shift in one step
  function automatic logic [31:0] shFull(input cpuma_shop_t op, input logic [31:0] v, input logic [4:0] a);
    logic [63:0] dbl;
    dbl = {v, v};
    case (op)
      SH_SLL: shFull = v << a;
      SH_SRL: shFull = v >> a;
      SH_SRA: shFull = $unsigned($signed(v) >>> a);
      SH_ROL: shFull = 32'(({dbl} << a) >> 32);
      SH_ROR: shFull = 32'(dbl >> a);
      default: shFull = v;
    endcase
  endfunction

  wire shIsRot = shOp == SH_ROL || shOp == SH_ROR;
  wire [2:0] shHwCyc = shIsRot ? SH_HW_ROT_CYC : SH_HW_SHIFT_CYC;
  wire [4:0] shHwCnt = 5'(shHwCyc - 3'h1);
  wire [31:0] shStep = shFull(shOp_reg, shWork_reg, 5'h1);
  assign shBusy = shState_reg == SS_BUSY;
  assign shDone = shBusy && shCnt_reg == 5'h0;
  assign shResult = shWork_reg;

  // Shift control: one bit per cycle when serial, fixed wait otherwise
  always_ff @(posedge mclk) begin
    if (srst) begin
      shState_reg <= SS_IDLE;
      shWork_reg <= 32'h0;
      shCnt_reg <= 5'h0;
      shOp_reg <= SH_SLL;
      shSerial_reg <= 1'b0;
    end else if (shState_reg == SS_IDLE) begin
      if (shStart) begin
        shState_reg <= SS_BUSY;
        shOp_reg <= shOp;
        shSerial_reg <= !hwMul;
        shWork_reg <= hwMul ? shFull(shOp, shValue, shAmount) : shValue;
        shCnt_reg <= hwMul ? shHwCnt : shAmount;
      end
    end else if (shCnt_reg != 5'h0) begin
      shCnt_reg <= shCnt_reg - 5'h1;
      if (shSerial_reg) shWork_reg <= shStep;
    end else begin
      shState_reg <= SS_IDLE;
    end
  end

  // ---------------- AHB-Lite registers ----------------
  logic ahbWr_reg;
  logic ahbRd_reg;
  logic [REG_AW-1:0] ahbAddr_reg;

  // Address phase decode and data phase selection
  wire ahbTake = hsel && hready && htrans[1];
  wire selCtrl = ahbAddr_reg == REG_CTRL;
  wire selStatus = ahbAddr_reg == REG_STATUS;
  wire [31:0] statusWord = {29'h0, shBusy, !dcIdle, icState_reg != IC_IDLE};
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = !ahbRd_reg ? 32'h0 : (selCtrl ? {30'h0, ctrl_reg} : (selStatus ? statusWord : 32'h0));

  // Bus phase capture and control register write
  always_ff @(posedge mclk) begin
    if (srst) begin
      ahbWr_reg <= 1'b0;
      ahbRd_reg <= 1'b0;
      ahbAddr_reg <= '0;
      ctrl_reg <= CTRL_RESET;
    end else begin
      ahbWr_reg <= ahbTake && hwrite;
      ahbRd_reg <= ahbTake && !hwrite;
      if (ahbTake) ahbAddr_reg <= haddr[REG_AW-1:0];
      if (ahbWr_reg && selCtrl) ctrl_reg <= hwdata[1:0];
    end
  end

endmodule // cpuma_core

// ==== cpuma_core_tb.sv ====
`timescale 1ns/100ps
module cpuma_core_tb import cpuma_pkg::*;;
  logic mclk = 1'b0, srst = 1'b1, ifReq = 1'b0, shStart = 1'b0, hsel = 1'b0, hwrite = 1'b0, rdPh = 1'b0;
  logic imS = 1'b0, dmS = 1'b0, ifReady, dReady, shDone, hreadyout, hresp;
  logic imWaitrequest, imReadvalid, dmWaitrequest, dmReadvalid;
  logic [31:0] ifAddr = '0, haddr = '0, hwdata = '0, shValue = '0, rs = 32'h06aa;
  logic [31:0] ifData, dRdata, shResult, imReaddata, dmReaddata, hrdata;
  logic [1:0] htrans = 2'h0;
  logic [4:0] shAmount = 5'h0;
  cpuma_shop_t shOp = SH_SLL;
  cpuma_dreq_t dReq = '0;
  cpuma_mreq_t imReq, dmReq;
  logic [31:0] qi[$], qd[$], qs[$], qh[$];
  int fail_count = 0, num_checks = 0;
  // Design and two memory slaves
  cpuma_core dut (.mclk, .srst, .ifReq, .ifAddr, .fetch_physical_frame_number('0), .ifReady, .ifData,
    .dReq, .physical_frame_number('0), .tlbUncached(1'b0), .dReady, .dRdata, .shStart, .shOp, .shValue,
    .shAmount, .shDone, .shResult, .imReq, .imWaitrequest, .imReadvalid, .imReaddata, .dmReq, .dmWaitrequest,
    .dmReadvalid, .dmReaddata, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
    .hreadyout, .hresp, .hrdata);
  cpuma_mem_model im (.mclk, .srst, .stall(imS), .req(imReq), .waitreq(imWaitrequest), .rvalid(imReadvalid),
    .rdata(imReaddata));
  cpuma_mem_model dm (.mclk, .srst, .stall(dmS), .req(dmReq), .waitreq(dmWaitrequest), .rvalid(dmReadvalid),
    .rdata(dmReaddata));
  initial forever #5 mclk = ~mclk;
  function automatic logic [31:0] xs();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  function automatic logic [31:0] pat(input logic [31:0] a);
    return {1'b0, a[30:0]} ^ 32'ha5a5_0000;
  endfunction
  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wt(ref logic s);
    int n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (s !== 1'b1 && n < 3000);
    if (n >= 3000) begin
      fail_count++;
      close_out();
    end
  endtask
  task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {20'h0, a};
    wt(hreadyout);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= w ? d : 32'h0;
    rdPh <= !w;
    if (!w) qh.push_back(d);
    wt(hreadyout);
    rdPh <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic fetch(input logic [31:0] a);
    qi.push_back(pat(a));
    ifReq <= 1'b1;
    ifAddr <= a;
    wt(ifReady);
    ifReq <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic dacc(input logic w, b, input cpuma_cop_t op, input logic [31:0] a, d);
    dReq <= '{1'b1, w, b, op, a, d};
    if (!w && op == CO_NONE) qd.push_back(d);
    wt(dReady);
    dReq.req <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic sh(input cpuma_shop_t o, input logic [4:0] a);
    logic [31:0] v, s;
    logic [63:0] y;
    v = xs();
    y = {v, v};
    s = $signed(v) >>> a;
    qs.push_back(o == SH_SLL ? v << a : o == SH_SRL ? v >> a : o == SH_SRA ? s : o == SH_ROL ? y[63-a -: 32] : y[a +: 32]);
    shOp <= o;
    shValue <= v;
    shAmount <= a;
    shStart <= 1'b1;
    @(posedge mclk);
    shStart <= 1'b0;
    wt(shDone);
    @(posedge mclk);
  endtask
  // Random slave stalls
  always @(posedge mclk) begin
    imS <= xs() > 32'hc000_0000;
    dmS <= rs[4] & rs[9];
  end
  // Each result takes the oldest note of its kind
  always @(posedge mclk) begin
    if (ifReady === 1'b1) chk("ifData", qi.pop_front(), ifData);
    if (dReady === 1'b1 && !dReq.write && dReq.op == CO_NONE) chk("dRdata", qd.pop_front(), dRdata);
    if (shDone === 1'b1) chk("shResult", qs.pop_front(), shResult);
    if (rdPh && hreadyout === 1'b1) chk("hrdata", qh.pop_front(), hrdata);
  end
  // Main sequence
  initial begin
    logic [31:0] r, r2;
    repeat (3) @(posedge mclk);
    srst <= 1'b0;
    ahb(0, REG_CTRL, 32'h2);
    ahb(0, REG_STATUS, 32'h0);
    ahb(0, 12'h008, 32'h0);
    ahb(1, REG_CTRL, 32'h3);
    ahb(0, REG_CTRL, 32'h3);
    for (int m = 0; m < 2; m++) begin
      if (m == 1) ahb(1, REG_CTRL, 32'hffff_fffc);
      for (int o = 0; o < 5; o++) for (int k = 0; k < 3; k++) sh(cpuma_shop_t'(o), k == 0 ? 5'h0 : k == 1 ? 5'h1f : 5'(xs()));
    end
    fetch(32'h0000_1234);
    fetch(32'h0000_1220);
    fetch(32'h0800_0010);
    dacc(0, 0, CO_NONE, 32'h2008, pat(32'h2008));
    r = xs();
    dacc(1, 0, CO_NONE, 32'h2008, r);
    dacc(0, 0, CO_NONE, 32'h2008, r);
    dacc(0, 0, CO_NONE, 32'h8000_2008, pat(32'h2008));
    dacc(0, 1, CO_NONE, 32'h2008, pat(32'h2008));
    dacc(0, 0, CO_FLUSH_ADDR, 32'h4008, 32'h0);
    dacc(0, 0, CO_FLUSH_IDX, 32'h2008, 32'h0);
    dacc(0, 0, CO_NONE, 32'h8000_2008, r);
    r2 = xs();
    dacc(1, 0, CO_NONE, 32'h2008, r2);
    dacc(0, 0, CO_INV_ADDR, 32'h2008, 32'h0);
    dacc(0, 0, CO_NONE, 32'h2008, r);
    dacc(1, 0, CO_NONE, 32'h2010, r2);
    dacc(0, 0, CO_NONE, 32'h2208, pat(32'h2208));
    dacc(0, 1, CO_NONE, 32'h2010, r2);
    dacc(1, 0, CO_NONE, 32'h2208, r);
    dacc(0, 0, CO_INV_IDX, 32'h2208, 32'h0);
    dacc(0, 0, CO_NONE, 32'h2208, pat(32'h2208));
    dacc(0, 0, CO_NONE, 32'h0800_0020, pat(32'h0800_0020));
    dacc(1, 1, CO_NONE, 32'h2018, r);
    dacc(0, 1, CO_NONE, 32'h2018, r);
    ahb(1, REG_CTRL, 32'h1);
    dacc(0, 0, CO_NONE, 32'h3004, pat(32'h3004));
    close_out();
  end
endmodule // cpuma_core_tb
bind cpuma_core cpuma_checker chk_i (.mclk, .srst, .ifAddr, .shStart, .shOp, .shAmount, .shDone, .imReq,
  .imWaitrequest, .dmReq, .dmWaitrequest, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp);

// ==== cpuma_mem_model.sv ====
`timescale 1ns/100ps
module cpuma_mem_model import cpuma_pkg::*; (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Bus slave side
  input wire logic stall,
  input cpuma_mreq_t req,
  output logic waitreq,
  output logic rvalid,
  output logic [31:0] rdata
);
  logic [31:0] mem[logic [31:0]];
  logic [31:0] pend[$];
  // Stall requests when the bench asks
  assign waitreq = stall;
  // Reads answered in order; idle data inverts its previous value every cycle
  always @(posedge mclk) begin
    logic [31:0] a;
    rvalid <= 1'b0;
    rdata <= ~rdata;
    if (srst) begin
      pend.delete();
      rdata <= 32'h0;
    end else begin
      if (pend.size() > 0) begin
        rvalid <= 1'b1;
        rdata <= pend.pop_front();
      end
      if (!stall && req.write) mem[req.addr] = req.wdata;
      for (int i = 0; i < 8; i++) begin
        a = req.addr + 32'(4 * i);
        if (!stall && req.read && i < int'(req.burstcount)) pend.push_back(mem.exists(a) ? mem[a] : a ^ 32'ha5a5_0000);
      end
    end
  end
endmodule // cpuma_mem_model

// ==== cpuma_pkg.sv ====
package cpuma_pkg;
  // Build options; the MMU option switches address width and bypass source
  localparam int MMU_ON = 0;
  localparam int TCM_PRESENT = 1;
  // Caches and master ports stay in with or without a tightly-coupled memory; the data master follows the data cache
  localparam int IC_EN = (TCM_PRESENT == 0) ? 1 : 1;
  localparam int DC_EN = 1;
  localparam int IM_EN = (TCM_PRESENT == 0) ? 1 : 1;
  localparam int DM_EN = (DC_EN == 0) ? 0 : 1;
  // Capacity of each cache, selectable from 512 bytes to 64 KB
  localparam int CACHE_MIN_BYTES = 512;
  localparam int CACHE_MAX_BYTES = 65536;
  localparam int IC_BYTES = 512;
  localparam int DC_BYTES = 512;
  // Line layout: 32-byte lines of 8 words, offset in the 5 low bits
  localparam int LINE_BYTES = 32;
  localparam int OFF_W = 5;
  localparam int WSEL_W = 3;
  localparam int PADDR_W = (MMU_ON != 0) ? 32 : 31;
  localparam int PAGE_W = 12;
  localparam int PFN_W = 32 - PAGE_W;
  localparam int BYPASS_BIT = 31;
  // Index width from capacity only, tag width from capacity and address width
  localparam int IC_LINES = IC_BYTES / LINE_BYTES;
  localparam int DC_LINES = DC_BYTES / LINE_BYTES;
  localparam int IC_IDX_W = $clog2(IC_LINES);
  localparam int DC_IDX_W = $clog2(DC_LINES);
  localparam int IC_TAG_W = PADDR_W - IC_IDX_W - OFF_W;
  localparam int DC_TAG_W = PADDR_W - DC_IDX_W - OFF_W;
  // Word counters
  localparam logic [3:0] WORDS_N = 4'h8;
  localparam logic [3:0] CNT_ONE = 4'h1;
  localparam logic [2:0] WORD_LAST = 3'h7;
  localparam logic [3:0] BURST_LEN = 4'h8;
  localparam logic [3:0] BURST_ONE = 4'h1;
  // Tightly-coupled memory span
  localparam logic [31:0] TCM_BASE = 32'h0800_0000;
  localparam logic [31:0] TCM_MASK = 32'hffff_0000;
  // Shift timing with the multiplier in use
  localparam logic [2:0] SH_HW_SHIFT_CYC = 3'h3;
  localparam logic [2:0] SH_HW_ROT_CYC = 3'h4;
  // Register map
  localparam int REG_AW = 12;
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam int CTRL_BURST = 0;
  localparam int CTRL_HWMUL = 1;
  localparam logic [1:0] CTRL_RESET = 2'h2;
  localparam int STAT_IC = 0;
  localparam int STAT_DC = 1;
  localparam int STAT_SH = 2;
  // Commands and modes
  typedef enum logic [2:0] {CO_NONE = 3'h0, CO_FLUSH_IDX = 3'h1, CO_FLUSH_ADDR = 3'h2,
                            CO_INV_IDX = 3'h3, CO_INV_ADDR = 3'h4} cpuma_cop_t;
  typedef enum logic [2:0] {SH_SLL = 3'h0, SH_SRL = 3'h1, SH_SRA = 3'h2,
                            SH_ROL = 3'h3, SH_ROR = 3'h4} cpuma_shop_t;
  // States
  typedef enum logic [3:0] {IC_IDLE = 4'b0001, IC_FILL = 4'b0010, IC_UNC = 4'b0100,
                            IC_RESP = 4'b1000} cpuma_icst_t;
  typedef enum logic [4:0] {DC_IDLE = 5'b00001, DC_WBACK = 5'b00010, DC_FILL = 5'b00100,
                            DC_UNC = 5'b01000, DC_RESP = 5'b10000} cpuma_dcst_t;
  typedef enum logic [1:0] {SS_IDLE = 2'b01, SS_BUSY = 2'b10} cpuma_shst_t;
  // Bus master request and pipeline data request
  typedef struct packed {
    logic read;
    logic write;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [3:0] burstcount;
  } cpuma_mreq_t;
  typedef struct packed {
    logic req;
    logic write;
    logic bypass;
    cpuma_cop_t op;
    logic [31:0] addr;
    logic [31:0] wdata;
  } cpuma_dreq_t;
endpackage
